// *** nssi_station.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "nssi_params.svh"
module nssi_station
#(
    parameter int unsigned START_TICKS = `NSSI_START_TICKS,
    parameter int unsigned TICK_DIV = `NSSI_TICK_DIV,
    parameter bit REPEATER = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Switch bank and straps (pins)
    input wire logic [`NSSI_ADDR_W-1:0] addr_switch,
    input wire logic cpu_present,
    // Software connect request (same clock)
    input wire logic connect_req,
    input wire logic disconnect_req,
    // Link activity and timeout wait (same clock)
    input wire logic rx_active,
    input wire logic tx_active,
    input wire logic timeout_wait,
    input wire logic fault,
    // Repeater transfer activity (same clock)
    input wire logic ext_to_trunk_act,
    input wire logic trunk_to_ext_act,
    // Remote status capture (same clock)
    input wire logic rstat_load,
    input wire logic rstat_comm_ok,
    input wire logic [`NSSI_RSTAT_W-2:0] rstat_remote,
    // Identity
    output logic [`NSSI_ADDR_W-1:0] station_addr,
    output logic addr_valid,
    // State and indicators
    output var nssi_pkg::nssi_state_t op_state,
    output logic led_ready,
    output logic led_busy,
    output logic led_ext_to_trunk,
    output logic led_trunk_to_ext,
    output logic bus_attached,
    output logic error,
    // Remote status
    output logic [`NSSI_RSTAT_W-1:0] remote_status
);
    import nssi_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [`NSSI_ADDR_W-1:0] sw_s1;
    logic [`NSSI_ADDR_W-1:0] sw_s2;
    logic cpu_s1;
    logic cpu_s2;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sw_s1 <= 8'h00;
            sw_s2 <= 8'h00;
            cpu_s1 <= 1'b0;
            cpu_s2 <= 1'b0;
        end else begin
            sw_s1 <= addr_switch;
            sw_s2 <= sw_s1;
            cpu_s1 <= cpu_present;
            cpu_s2 <= cpu_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time base
    nssi_tick_if tk_if();

    nssi_prescaler #(
        .DIV(TICK_DIV)
    ) u_pre (
        .clk(clk),
        .rst(rst),
        .tk(tk_if.src)
    );

    ////////////////////////////////////////////////////////////////////////
    // State machine and timers
    nssi_state_t state;
    nssi_state_t next_state;
    logic [31:0] start_cnt;
    logic [31:0] next_start_cnt;
    logic [7:0] blink_cnt;
    logic [7:0] next_blink_cnt;
    logic blink;
    logic next_blink;
    logic standalone;
    logic next_standalone;
    logic [1:0] strap_cnt;
    logic [1:0] next_strap_cnt;
    logic attached;
    logic next_attached;
    logic [`NSSI_ADDR_W-1:0] addr;
    logic [`NSSI_ADDR_W-1:0] next_addr;
    logic addr_ok;
    logic next_addr_ok;
    logic activity;

    // Busy covers traffic and the timeout wait
    assign activity = rx_active | tx_active | timeout_wait;

    always_comb begin
        next_state = state;
        next_start_cnt = start_cnt;
        next_blink_cnt = blink_cnt;
        next_blink = blink;
        next_standalone = standalone;
        next_strap_cnt = strap_cnt;
        next_attached = attached;
        next_addr = addr;
        next_addr_ok = addr_ok;
        // Strap read once, when cpu_s2 holds the pin; both lamps lit till then
        if (strap_cnt != 2'h3) begin
            next_strap_cnt = strap_cnt + 2'h1;
        end
        if (strap_cnt == 2'h2) begin
            next_standalone = ~cpu_s2;
        end
        // Address held while 255 is on the switches
        if (sw_s2 != `NSSI_ADDR_RESERVED) begin
            next_addr = sw_s2;
            next_addr_ok = 1'b1;
        end else begin
            next_addr_ok = 1'b0;
        end
        // Attachment only; no effect on state
        if (connect_req) begin
            next_attached = 1'b1;
        end else if (disconnect_req) begin
            next_attached = 1'b0;
        end
        if (tk_if.tick) begin
            if (blink_cnt >= 8'(`NSSI_BLINK_TICKS - 1)) begin
                next_blink_cnt = 8'h00;
                next_blink = ~blink;
            end else begin
                next_blink_cnt = blink_cnt + 8'h01;
            end
        end
        unique case (state)
            NSSI_START: begin
                if (tk_if.tick) begin
                    if (start_cnt >= 32'(START_TICKS - 1)) begin
                        next_state = NSSI_READY;
                    end else begin
                        next_start_cnt = start_cnt + 32'h1;
                    end
                end
            end
            NSSI_READY: begin
                if (activity) begin
                    next_state = NSSI_BUSY;
                end
            end
            NSSI_BUSY: begin
                if (!activity) begin
                    next_state = NSSI_READY;
                end
            end
            default: begin
                next_state = NSSI_START;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= NSSI_START;
            start_cnt <= 32'h0;
            blink_cnt <= 8'h00;
            blink <= 1'b0;
            standalone <= 1'b0;
            strap_cnt <= 2'h0;
            attached <= 1'b0;
            addr <= 8'h00;
            addr_ok <= 1'b0;
        end else begin
            state <= next_state;
            start_cnt <= next_start_cnt;
            blink_cnt <= next_blink_cnt;
            blink <= next_blink;
            standalone <= next_standalone;
            strap_cnt <= next_strap_cnt;
            attached <= next_attached;
            addr <= next_addr;
            addr_ok <= next_addr_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indicators and status outputs
    logic next_led_ready;
    logic next_led_busy;
    logic next_err;
    logic [`NSSI_RSTAT_W-1:0] next_rstat;

    always_comb begin
        next_rstat = remote_status;
        if (rstat_load) begin
            // Bit zero success, upper nine clear when the remote is healthy
            next_rstat = {rstat_remote, rstat_comm_ok};
        end
        next_err = 1'b0;
        if (state == NSSI_START) begin
            next_led_busy = 1'b1;
            next_led_ready = standalone ? blink : 1'b1;
        end else begin
            // A fault drops ready so the lamp shows the error
            next_led_ready = ~fault;
            next_err = fault;
            next_led_busy = (state == NSSI_BUSY);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            station_addr <= 8'h00;
            addr_valid <= 1'b0;
            op_state <= NSSI_START;
            led_ready <= 1'b0;
            led_busy <= 1'b0;
            led_ext_to_trunk <= 1'b0;
            led_trunk_to_ext <= 1'b0;
            bus_attached <= 1'b0;
            error <= 1'b0;
            remote_status <= 10'h000;
        end else begin
            station_addr <= addr;
            addr_valid <= addr_ok;
            op_state <= state;
            led_ready <= next_led_ready;
            led_busy <= next_led_busy;
            led_ext_to_trunk <= REPEATER & ext_to_trunk_act;
            led_trunk_to_ext <= REPEATER & trunk_to_ext_act;
            bus_attached <= attached;
            error <= next_err;
            remote_status <= next_rstat;
        end
    end
endmodule // nssi_station
`default_nettype wire

// *** nssi_params.svh ***
`ifndef NSSI_PARAMS_SVH
`define NSSI_PARAMS_SVH

// Station address range
`define NSSI_ADDR_W 8
`define NSSI_ADDR_RESERVED 8'hff
// Remote status width and its fields
`define NSSI_RSTAT_W 10
`define NSSI_RSTAT_OK_POS 0
// Clock and time base
`define NSSI_CLK_HZ 20000000
`define NSSI_TICK_HZ 100
`define NSSI_TICK_DIV (`NSSI_CLK_HZ / `NSSI_TICK_HZ)
// Start-up interval in seconds
`define NSSI_START_S 15
`define NSSI_START_TICKS (`NSSI_START_S * `NSSI_TICK_HZ)
// Ready blink half period in ticks
`define NSSI_BLINK_TICKS 25

`endif

// *** nssi_pkg.sv ***
package nssi_pkg;
    typedef enum logic [1:0] {
        NSSI_START = 2'b00,
        NSSI_READY = 2'b01,
        NSSI_BUSY = 2'b10
    } nssi_state_t;
endpackage

// *** nssi_tick_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface nssi_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface
`default_nettype wire

// *** nssi_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "nssi_params.svh"
module nssi_prescaler #(
    parameter int unsigned DIV = `NSSI_TICK_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Tick out
    nssi_tick_if.src tk
);
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic pulse;
    logic next_pulse;

    always_comb begin
        next_pulse = 1'b0;
        next_cnt = cnt + 32'h1;
        if (cnt >= 32'(DIV - 1)) begin
            next_cnt = 32'h0;
            next_pulse = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 32'h0;
            pulse <= 1'b0;
        end else begin
            cnt <= next_cnt;
            pulse <= next_pulse;
        end
    end

    assign tk.tick = pulse;
endmodule // nssi_prescaler
`default_nettype wire

// *** nssi_station_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "nssi_params.svh"
module nssi_station_chk
#(
    parameter int unsigned START_TICKS = 10,
    parameter int unsigned TICK_DIV = 4,
    parameter bit REPEATER = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Inputs watched
    input wire logic [`NSSI_ADDR_W-1:0] addr_switch,
    input wire logic connect_req,
    input wire logic rx_active,
    input wire logic fault,
    input wire logic ext_to_trunk_act,
    input wire logic rstat_load,
    input wire logic rstat_comm_ok,
    input wire logic [`NSSI_RSTAT_W-2:0] rstat_remote,
    // Outputs watched
    input wire logic [`NSSI_ADDR_W-1:0] station_addr,
    input wire logic addr_valid,
    input var nssi_pkg::nssi_state_t op_state,
    input wire logic led_busy,
    input wire logic led_ext_to_trunk,
    input wire logic bus_attached,
    input wire logic error,
    input wire logic [`NSSI_RSTAT_W-1:0] remote_status
);
import nssi_pkg::*;
default clocking @(posedge clk); endclocking
default disable iff (rst);
////////////////////////////////////////////////////////////////////////
// Switch takes 2 sync flops plus two registers (addr, then station_addr)
property p_addr;
    ($stable(addr_switch) && addr_switch != 8'hff)[*6]
        |-> station_addr == addr_switch && addr_valid;
endproperty
a_addr: assert property (p_addr) else $error("address not adopted");
property p_res;
    (addr_switch == 8'hff)[*6] |-> !addr_valid;
endproperty
a_res: assert property (p_res) else $error("reserved address taken");
property p_rst;
    rstat_load |=> remote_status[0] == $past(rstat_comm_ok)
        && remote_status[9:1] == $past(rstat_remote);
endproperty
a_rst: assert property (p_rst) else $error("remote status wrong");
property p_e2t;
    1'b1 |=> led_ext_to_trunk == (REPEATER && $past(ext_to_trunk_act));
endproperty
a_e2t: assert property (p_e2t) else $error("transfer lamp wrong");
property p_conn;
    // Attach flop then output flop
    connect_req |-> ##2 bus_attached;
endproperty
a_conn: assert property (p_conn) else $error("bus not attached");
property p_st;
    op_state != 2'b11;
endproperty
a_st: assert property (p_st) else $error("illegal state");
property p_busy;
    op_state == NSSI_READY && rx_active |-> ##[1:3] led_busy;
endproperty
a_busy: assert property (p_busy) else $error("busy lamp late");
property p_err;
    fault && op_state != NSSI_START |-> ##[1:2] error;
endproperty
a_err: assert property (p_err) else $error("fault not flagged");
c_busy: cover property (op_state == NSSI_BUSY);
c_res: cover property (!addr_valid ##1 addr_valid);
c_err: cover property (error);
endmodule // nssi_station_chk
bind nssi_station nssi_station_chk #(.START_TICKS(START_TICKS),
    .TICK_DIV(TICK_DIV), .REPEATER(REPEATER)) i_chk (.*);
`default_nettype wire

// *** nssi_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module nssi_peer (
    // Clock and commands
    input wire logic clk,
    input wire logic [1:0] cmd,
    input wire logic poll,
    // Activity and status answer
    output logic rx_active,
    output logic tx_active,
    output logic timeout_wait,
    output logic rstat_load,
    output logic [9:0] rstat
);
logic [9:0] base = 10'h000;
always @(negedge clk) begin
    rx_active <= cmd == 2'h1;
    tx_active <= cmd == 2'h2;
    timeout_wait <= cmd == 2'h3;
    rstat_load <= poll;
    if (poll) begin
        base <= base + 10'h025;
    end
    // Idle data is inverted so a stale value never looks valid
    rstat <= poll ? base + 10'h025 : ~base;
end
endmodule // nssi_peer
`default_nettype wire

// *** nssi_station_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module nssi_station_tb_top;
import nssi_pkg::*;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
logic clk, rst, con, dis, flt, e2t, t2e, poll, rxa, txa, tow, ld, cpu;
logic [1:0] cmd;
logic [7:0] sw, sa, v;
logic [9:0] rs, rstat;
logic av, lr, lb, le, lt, ba, er;
nssi_state_t st;
int failures, tests_run, exp_a;
logic [9:0] q[$];
// Start-up outlasts one blink half period so the blink shows
nssi_station #(.START_TICKS(40), .TICK_DIV(4), .REPEATER(1'b1)) i_dut (
    .clk(clk), .rst(rst), .addr_switch(sw), .cpu_present(cpu),
    .connect_req(con), .disconnect_req(dis), .rx_active(rxa),
    .tx_active(txa), .timeout_wait(tow), .fault(flt),
    .ext_to_trunk_act(e2t), .trunk_to_ext_act(t2e), .rstat_load(ld),
    .rstat_comm_ok(rstat[0]), .rstat_remote(rstat[9:1]),
    .station_addr(sa), .addr_valid(av), .op_state(st), .led_ready(lr),
    .led_busy(lb), .led_ext_to_trunk(le), .led_trunk_to_ext(lt),
    .bus_attached(ba), .error(er), .remote_status(rs));
nssi_peer i_peer (.clk(clk), .cmd(cmd), .poll(poll), .rx_active(rxa),
    .tx_active(txa), .timeout_wait(tow), .rstat_load(ld), .rstat(rstat));
always #25 clk = ~clk;
always @(posedge clk) if (ld) q.push_back(rstat);
always @(negedge clk) if (q.size() > 0) `CHK(rs, q.pop_front())
task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
endtask
task automatic cyc(input int n);
    repeat (n) @(negedge clk);
endtask
initial begin
    #(50 * 3000);
    failures++;
    close_out();
end
initial begin
    clk = 0; rst = 1; sw = 0; con = 0; dis = 0; flt = 0; e2t = 0;
    t2e = 0; poll = 0; cmd = 0; exp_a = 0; cpu = 0;
    void'($urandom(74));
    // Second pass is a mid-run reset with the control processor present
    for (int r = 0; r < 2; r++) begin
        cpu = r[0];
        cyc(6);
        rst = 0;
        cyc(5);
        `CHK(st, NSSI_START)
        `CHK({lb, lr}, {1'b1, cpu})
        // Blink flips on the 25th tick, edge 101 after release
        cyc(96);
        `CHK({lb, lr}, {1'b1, cpu})
        cyc(1);
        `CHK({lb, lr}, 2'b11)
        // Tick 40 lands on edge 161, shown one edge later
        cyc(59);
        `CHK(st, NSSI_START)
        cyc(1);
        `CHK(st, NSSI_READY)
        `CHK(lr, 1'b1)
        `CHK(sa, exp_a[7:0])
        if (r == 0) begin
            for (int i = 0; i < 7; i++) begin
                v = i == 0 ? 8'hfe : i[0] ? 8'hff : 8'($urandom % 255);
                if (v != 8'hff) exp_a = v;
                sw <= v;
                cyc(6);
                `CHK(sa, exp_a[7:0])
                `CHK(av, v != 8'hff)
            end
            for (int i = 0; i < 4; i++) begin
                poll <= i < 3;
                cyc(1);
            end
            poll <= 0;
            cyc(3);
            for (int c = 1; c < 4; c++) begin
                cmd <= 2'(c);
                cyc(4);
                `CHK(lb, 1'b1)
                `CHK(st, NSSI_BUSY)
            end
            cmd <= 0;
            cyc(4);
            `CHK(st, NSSI_READY)
            e2t <= 1;
            cyc(2);
            `CHK({le, lt}, 2'b10)
            e2t <= 0; t2e <= 1;
            cyc(2);
            `CHK({le, lt}, 2'b01)
            con <= 1; dis <= 1;
            cyc(2);
            `CHK(ba, 1'b1)
            `CHK(st, NSSI_READY)
            con <= 0;
            cyc(2);
            `CHK(ba, 1'b0)
            rst = 1;
        end
    end
    flt <= 1;
    cyc(3);
    `CHK({er, lr}, 2'b10)
    close_out();
end
endmodule // nssi_station_tb_top
`default_nettype wire
